/* File: logic/gpio_hs_map.vh */
// Constants for the handshake parallel port block: register map, fields.
// Assumes a single 100 MHz clock and the plain register port of the top.
// Notes on behaviour
// R1: Direction bit 1 input, 0 output
// R2: Polarity bit 1 inverts line data
// R3: Reads: inputs sampled, outputs driven, C pins
// R4: Ones catcher latches 1, cleared writing 0
// R5: Special bit on output selects open-drain
// R6: Port C upper nibble protects lower bits
// R7: Handshake ports are double-buffered
// R8: Byte moved sets int_pending, requests interrupt
// R9: Auto-clear on data access; bidirectional by command
// R10: Two-byte mode interrupts on two bytes only
// R11: Single buffer bit holds only one byte
// R12: Link bit joins A and B, 16 bits
// R13: Software accesses B data before A data
// R14: Port type sets direction; no input catchers
// R15: Handshake forces Port C lines to outputs
// R16: Port A uses lines 3 and 2
// R17: Port B uses lines 1 and 0
// R18: Three-wire uses lines 3, 2 and 0
// R19: Bidirectional uses line 0 as direction
// R20: Interlocked waits for the far side each step
// R21: Deskew holds data_available for time plus one
// R22: Strobed moves data on ack_input falling edge
// R23: All pin inputs pass two flip-flops
`ifndef GPIO_HS_MAP_VH
`define GPIO_HS_MAP_VH

`define SEL_A     2'h0
`define SEL_B     2'h1
`define SEL_C     2'h2
`define REG_DATA  3'h0
`define REG_DIR   3'h1
`define REG_POL   3'h2
`define REG_SPC   3'h3
`define REG_MODE  3'h4
`define REG_CSR   3'h5
`define REG_DSK   3'h6

`define RST_DIR8  8'hff
`define RST_DIR4  4'hf
`define ZERO8     8'h00
`define ZERO4     4'h0

`define MD_PT     1:0
`define MD_HS     3:2
`define MD_TWO_BYTE 4
`define MD_SINGLE 5
`define MD_LINK   6
`define PT_BIT    2'h0
`define PT_IN     2'h1
`define PT_OUT    2'h2
`define PT_BI     2'h3
`define HS_STB    2'h1
`define HS_3W     2'h3
`define CSR_PEND  0
`define DSK_TC    3:0
`define DSK_EN    4

`define CNT_ZERO  2'h0
`define CNT_ONE   2'h1
`define CNT_TWO   2'h2

`define A_OUT_LN  2'h3
`define A_ACK_LN  2'h2
`define B_OUT_LN  2'h1
`define B_ACK_LN  2'h0
`define W3_OUT_LN 2'h3
`define W3_IN_LN  2'h2
`define W3_AUX_LN 2'h0
`define BIDIR_LN  0

`endif

/* File: logic/gpio_hs_top.v */
// Two 8-bit ports with bit or handshake operation plus a 4-bit port C.
// Assumes software on the plain register port and synchronous pin drivers.
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`include "gpio_hs_map.vh"

////////////////////////////////////////////////////////////////////////////
module gpio_hs_port #(
  parameter [1:0] OUT_LINE = `A_OUT_LN,
  parameter [1:0] ACK_LINE = `A_ACK_LN
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       wr_en,
  input  wire       rd_en,
  input  wire [2:0] idx,
  input  wire [7:0] wdata,
  input  wire       hi_wr,
  input  wire [7:0] pin_s,
  input  wire [7:0] hi_s,
  input  wire [3:0] pc_s,
  output reg  [7:0] rdata,
  output wire [7:0] hi_rdata,
  output wire [7:0] pin_drv,
  output wire [7:0] pin_oe_n,
  output wire [7:0] hi_drv,
  output wire [7:0] hi_oe_n,
  output reg  [3:0] pc_drv,
  output reg  [3:0] pc_own,
  output wire       link,
  output reg        int_pending
);
  reg  [7:0]  dir_r, pol_r, spc_r, out_r, catch_r, mode_r, hi_stage_r;
  reg  [4:0]  dsk_r, dsk_cnt_r;
  reg  [15:0] q0_r, q1_r;
  reg  [1:0]  cnt_r;
  reg         ack_d_r, ready_r, avail_n_r, dac_r;

  wire       hs_on   = mode_r[`MD_PT] != `PT_BIT;
  wire       strb    = mode_r[`MD_HS] == `HS_STB;
  wire       bidir   = mode_r[`MD_PT] == `PT_BI;
  wire       tw      = (mode_r[`MD_HS] == `HS_3W) & ~bidir;
  wire       two_byte = mode_r[`MD_TWO_BYTE];
  wire [1:0] oline   = tw ? `W3_OUT_LN : OUT_LINE;
  // Port type decides direction; bidirectional follows its select line
  wire       dir_out = (mode_r[`MD_PT] == `PT_OUT) |
                       (bidir & pc_s[`BIDIR_LN]); // R14 R19
  wire       ack_l   = tw ? pc_s[`W3_IN_LN] : pc_s[ACK_LINE]; // R16 R17 R18
  wire       fall    = ack_d_r & ~ack_l;
  wire [1:0] cap     = mode_r[`MD_SINGLE] ? `CNT_ONE : `CNT_TWO; // R11
  wire       room    = cnt_r < cap; // R7
  wire       nonempty = cnt_r != `CNT_ZERO;
  wire [7:0] pin_pol = pin_s ^ pol_r; // R2
  wire       dwr     = wr_en & (idx == `REG_DATA);
  wire       drd     = rd_en & (idx == `REG_DATA);
  wire       dsk_done = ~dsk_r[`DSK_EN] | (dsk_cnt_r == 5'h00);

  // A write to a full buffer is dropped; software checks the count first
  wire cpu_push = hs_on & dir_out & dwr & room;
  wire cpu_pop  = hs_on & ~dir_out & drd & nonempty;
  wire in_take  = hs_on & ~dir_out & fall & (strb ? room : ready_r); // R22
  wire out_rdy  = tw ? pc_s[`W3_AUX_LN] : ack_l;
  wire out_acc  = strb ? (fall & nonempty) :
                  (~avail_n_r & (tw ? pc_s[`W3_IN_LN] : ~ack_l)); // R20 R22
  wire hs_pop   = hs_on & dir_out & out_acc;
  wire push     = cpu_push | in_take;
  wire pop      = cpu_pop | hs_pop;
  wire [15:0] push_d = dir_out ? {hi_stage_r, wdata} : {hi_s, pin_pol};
  wire [1:0] cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  wire new_head = (push & (cnt_r == `CNT_ZERO)) |
                  (pop & (cnt_r == `CNT_TWO)) |
                  (push & pop & (cnt_r == `CNT_ONE));

  wire pend_set  = hs_on & (dir_out ?
                   hs_pop & (~two_byte | (cnt_nxt == `CNT_ZERO)) :
                   in_take & (~two_byte | (cnt_nxt == cap))); // R8 R10
  wire pend_auto = hs_on & ~bidir & (dir_out ?
                   cpu_push & (~two_byte | (cnt_nxt == cap)) :
                   cpu_pop & (~two_byte | (cnt_nxt == `CNT_ZERO))); // R9 R10
  wire pend_cmd  = wr_en & (idx == `REG_CSR) & wdata[`CSR_PEND]; // R9

  // Ones catchers only exist on bit-mode inputs
  wire [7:0] armed    = spc_r & dir_r & {8{~hs_on}}; // R4 R14
  wire [7:0] catch_nx = (armed & pin_pol) |
                        (catch_r & armed & ~({8{dwr}} & ~wdata)); // R4
  wire [7:0] bit_rd   = (dir_r & ((spc_r & catch_r) | (~spc_r & pin_pol))) |
                        (~dir_r & out_r); // R3
  wire [7:0] drv_val  = hs_on ? (q0_r[7:0] ^ pol_r) : (out_r ^ pol_r); // R2
  wire [7:0] is_out   = hs_on ? {8{dir_out}} : ~dir_r; // R1 R14
  wire [7:0] drv_en   = is_out & (~spc_r | ~drv_val); // R5

  assign pin_drv  = drv_val;
  assign pin_oe_n = ~drv_en;
  assign link     = mode_r[`MD_LINK];
  assign hi_drv   = q0_r[15:8];
  assign hi_oe_n  = ~{8{hs_on & link & dir_out}}; // R12
  assign hi_rdata = q0_r[15:8]; // R13

  always @* begin
    case (idx)
      `REG_DATA: rdata = hs_on ? q0_r[7:0] : bit_rd; // R3
      `REG_DIR:  rdata = dir_r;
      `REG_POL:  rdata = pol_r;
      `REG_SPC:  rdata = spc_r;
      `REG_MODE: rdata = mode_r;
      `REG_CSR:  rdata = {5'h00, cnt_r, int_pending};
      `REG_DSK:  rdata = {3'h0, dsk_r};
      default:   rdata = `ZERO8;
    endcase
  end

  // Handshake lines claimed from port C
  always @* begin
    pc_own = `ZERO4;
    pc_drv = `ZERO4;
    if (hs_on) begin
      pc_own[oline] = 1'b1; // R15 R16 R17
      pc_drv[oline] = dir_out ? avail_n_r : ready_r;
      if (tw & ~dir_out) begin
        pc_own[`W3_AUX_LN] = 1'b1; // R18
        pc_drv[`W3_AUX_LN] = dac_r;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_r       <= `RST_DIR8;
      pol_r       <= `ZERO8;
      spc_r       <= `ZERO8;
      out_r       <= `ZERO8;
      catch_r     <= `ZERO8;
      mode_r      <= `ZERO8;
      hi_stage_r  <= `ZERO8;
      dsk_r       <= 5'h00;
      dsk_cnt_r   <= 5'h00;
      q0_r        <= 16'h0000;
      q1_r        <= 16'h0000;
      cnt_r       <= `CNT_ZERO;
      ack_d_r     <= 1'b1;
      ready_r     <= 1'b0;
      avail_n_r   <= 1'b1;
      dac_r       <= 1'b0;
      int_pending <= 1'b0;
    end else begin
      if (wr_en && idx == `REG_DIR)
        dir_r <= wdata;
      if (wr_en && idx == `REG_POL)
        pol_r <= wdata;
      if (wr_en && idx == `REG_SPC)
        spc_r <= wdata;
      if (wr_en && idx == `REG_MODE)
        mode_r <= wdata;
      if (wr_en && idx == `REG_DSK)
        dsk_r <= wdata[4:0];
      if (hi_wr)
        hi_stage_r <= wdata; // R13
      if (dwr && !hs_on)
        out_r <= (out_r & dir_r) | (wdata & ~dir_r); // R4
      catch_r <= catch_nx; // R4
      ack_d_r <= ack_l;
      // Set wins over any clear in the same cycle
      int_pending <= pend_set | (int_pending & ~(pend_auto | pend_cmd)); // R8 R9

      if (!hs_on) begin
        cnt_r <= `CNT_ZERO;
      end else begin
        cnt_r <= cnt_nxt; // R7
        case ({push, pop})
          2'b10: begin
            if (cnt_r == `CNT_ZERO)
              q0_r <= push_d;
            else
              q1_r <= push_d;
          end
          2'b01: q0_r <= q1_r;
          2'b11: begin
            if (cnt_r == `CNT_ONE) begin
              q0_r <= push_d;
            end else begin
              q0_r <= q1_r;
              q1_r <= push_d;
            end
          end
          default: q0_r <= q0_r;
        endcase
      end

      if (new_head)
        dsk_cnt_r <= {1'b0, dsk_r[`DSK_TC]} + 5'h01; // R21
      else if (dsk_cnt_r != 5'h00)
        dsk_cnt_r <= dsk_cnt_r - 5'h01;

      if (!hs_on || !dir_out)
        avail_n_r <= 1'b1;
      else if (strb)
        avail_n_r <= ~(nonempty & dsk_done & ~new_head); // R21 R22
      else if (avail_n_r && nonempty && dsk_done && !new_head && out_rdy)
        avail_n_r <= 1'b0; // R20 R21
      else if (out_acc)
        avail_n_r <= 1'b1; // R20

      if (!hs_on || dir_out)
        ready_r <= 1'b0;
      else if (strb)
        ready_r <= cnt_nxt < cap; // R22
      else if (in_take)
        ready_r <= 1'b0;
      else if (!ready_r && ack_l && room && !dac_r)
        ready_r <= 1'b1; // R20

      if (!(hs_on && tw && !dir_out))
        dac_r <= 1'b0;
      else if (in_take)
        dac_r <= 1'b1; // R18
      else if (ack_l)
        dac_r <= 1'b0;
    end
  end
endmodule // gpio_hs_port

////////////////////////////////////////////////////////////////////////////
module gpio_hs_top (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [4:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  input  wire [7:0] pa_in,
  output reg  [7:0] pa_out,
  output reg  [7:0] pa_oe_n,
  input  wire [7:0] pb_in,
  output reg  [7:0] pb_out,
  output reg  [7:0] pb_oe_n,
  input  wire [3:0] pc_in,
  output reg  [3:0] pc_out,
  output reg  [3:0] pc_oe_n,
  output reg        int_pending_a,
  output reg        int_pending_b
);
  reg        rst_m_r, rst_s_r;
  reg  [7:0] pa_m_r, pa_s_r, pb_m_r, pb_s_r;
  reg  [3:0] pc_m_r, pc_s_r;
  reg  [3:0] c_dir_r, c_pol_r, c_spc_r, c_out_r;
  wire [7:0] a_rd, b_rd, a_hi_rd, a_drv, a_oe_n, b_drv, b_oe_n;
  wire [7:0] a_hi_drv, a_hi_oe_n;
  wire [3:0] a_pc_drv, a_pc_own, b_pc_drv, b_pc_own;
  wire       link, a_ip, b_ip;

  wire [1:0] sel   = addr[4:3];
  wire [2:0] idx   = addr[2:0];
  wire       b_dat = (sel == `SEL_B) & (idx == `REG_DATA) & link;
  wire       c_acc = sel == `SEL_C;
  wire [3:0] pc_pol = pc_s_r ^ c_pol_r; // R15
  wire [3:0] own   = a_pc_own | b_pc_own;
  wire [3:0] c_val = (own & (a_pc_drv | b_pc_drv)) | (~own & c_out_r);
  wire [3:0] c_pin = c_val ^ c_pol_r; // R2 R15
  // Claimed lines drive regardless of port C direction
  wire [3:0] c_en  = (own | ~c_dir_r) & (~c_spc_r | ~c_pin); // R1 R5 R15
  reg  [7:0] rd_mux;

  // Reset is released through two flops; pins pass two flops as well
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end

  always @(posedge clk or negedge rst_s_r) begin
    if (!rst_s_r) begin
      pa_m_r <= `ZERO8;
      pa_s_r <= `ZERO8;
      pb_m_r <= `ZERO8;
      pb_s_r <= `ZERO8;
      pc_m_r <= `ZERO4;
      pc_s_r <= `ZERO4;
    end else begin
      pa_m_r <= pa_in; // R23
      pa_s_r <= pa_m_r;
      pb_m_r <= pb_in;
      pb_s_r <= pb_m_r;
      pc_m_r <= pc_in;
      pc_s_r <= pc_m_r;
    end
  end

  gpio_hs_port #(.OUT_LINE(`A_OUT_LN), .ACK_LINE(`A_ACK_LN)) u_port_a (
    .clk         (clk),
    .rst_n       (rst_s_r),
    .wr_en       (wr & (sel == `SEL_A)),
    .rd_en       (rd & (sel == `SEL_A)),
    .idx         (idx),
    .wdata       (wdata),
    .hi_wr       (wr & b_dat),
    .pin_s       (pa_s_r),
    .hi_s        (pb_s_r),
    .pc_s        (pc_pol),
    .rdata       (a_rd),
    .hi_rdata    (a_hi_rd),
    .pin_drv     (a_drv),
    .pin_oe_n    (a_oe_n),
    .hi_drv      (a_hi_drv),
    .hi_oe_n     (a_hi_oe_n),
    .pc_drv      (a_pc_drv),
    .pc_own      (a_pc_own),
    .link        (link),
    .int_pending (a_ip)
  );

  gpio_hs_port #(.OUT_LINE(`B_OUT_LN), .ACK_LINE(`B_ACK_LN)) u_port_b (
    .clk         (clk),
    .rst_n       (rst_s_r),
    .wr_en       (wr & (sel == `SEL_B) & ~b_dat), // R12
    .rd_en       (rd & (sel == `SEL_B) & ~b_dat),
    .idx         (idx),
    .wdata       (wdata),
    .hi_wr       (1'b0),
    .pin_s       (pb_s_r),
    .hi_s        (`ZERO8),
    .pc_s        (pc_pol),
    .rdata       (b_rd),
    .hi_rdata    (),
    .pin_drv     (b_drv),
    .pin_oe_n    (b_oe_n),
    .hi_drv      (),
    .hi_oe_n     (),
    .pc_drv      (b_pc_drv),
    .pc_own      (b_pc_own),
    .link        (),
    .int_pending (b_ip)
  );

  always @* begin
    case (sel)
      `SEL_A: rd_mux = a_rd;
      `SEL_B: rd_mux = b_dat ? a_hi_rd : b_rd; // R12 R13
      `SEL_C: begin
        case (idx)
          `REG_DATA: rd_mux = {4'h0, pc_pol}; // R3
          `REG_DIR:  rd_mux = {4'h0, c_dir_r};
          `REG_POL:  rd_mux = {4'h0, c_pol_r};
          `REG_SPC:  rd_mux = {4'h0, c_spc_r};
          default:   rd_mux = `ZERO8;
        endcase
      end
      default: rd_mux = `ZERO8;
    endcase
  end

  // All pin outputs are registered, so they lag the logic by one cycle
  always @(posedge clk or negedge rst_s_r) begin
    if (!rst_s_r) begin
      c_dir_r       <= `RST_DIR4;
      c_pol_r       <= `ZERO4;
      c_spc_r       <= `ZERO4;
      c_out_r       <= `ZERO4;
      rdata         <= `ZERO8;
      pa_out        <= `ZERO8;
      pa_oe_n       <= `RST_DIR8;
      pb_out        <= `ZERO8;
      pb_oe_n       <= `RST_DIR8;
      pc_out        <= `ZERO4;
      pc_oe_n       <= `RST_DIR4;
      int_pending_a <= 1'b0;
      int_pending_b <= 1'b0;
    end else begin
      if (wr && c_acc && idx == `REG_DIR)
        c_dir_r <= wdata[3:0];
      if (wr && c_acc && idx == `REG_POL)
        c_pol_r <= wdata[3:0];
      if (wr && c_acc && idx == `REG_SPC)
        c_spc_r <= wdata[3:0];
      if (wr && c_acc && idx == `REG_DATA)
        c_out_r <= (c_out_r & wdata[7:4]) | (wdata[3:0] & ~wdata[7:4]); // R6
      rdata         <= rd ? rd_mux : `ZERO8;
      pa_out        <= a_drv;
      pa_oe_n       <= a_oe_n;
      pb_out        <= link ? a_hi_drv : b_drv; // R12
      pb_oe_n       <= link ? a_hi_oe_n : b_oe_n;
      pc_out        <= c_pin;
      pc_oe_n       <= ~c_en;
      int_pending_a <= a_ip;
      int_pending_b <= b_ip;
    end
  end
endmodule // gpio_hs_top

/* File: verification/gpio_hs_checker.sv */
// Checker for the handshake parallel port block, bound to its top module.
// Assumes one clock and software that never raises wr and rd together.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
module gpio_hs_checker (
  input wire       clk,
  input wire       rst_n,
  input wire [4:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  input wire [7:0] pa_in,
  input wire [7:0] pa_out,
  input wire [7:0] pa_oe_n,
  input wire [7:0] pb_in,
  input wire [7:0] pb_out,
  input wire [7:0] pb_oe_n,
  input wire [3:0] pc_in,
  input wire [3:0] pc_out,
  input wire [3:0] pc_oe_n,
  input wire       int_pending_a,
  input wire       int_pending_b
);
  reg  [7:0] mode_a_r;
  reg  [7:0] spc_a_r;
  reg  [7:0] dir_a_r;
  wire       hs_a   = mode_a_r[1:0] != 2'h0;
  wire       il_out = mode_a_r[3:0] == 4'h2;
  wire       out_a  = mode_a_r[1:0] == 2'h2 && spc_a_r == 8'h00;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Shadow of port A setup, so rules can be scoped to the active mode
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_a_r <= 8'h00;
      spc_a_r  <= 8'h00;
      dir_a_r  <= 8'hff;
    end else if (wr) begin
      if (addr == 5'h04) mode_a_r <= wdata;
      if (addr == 5'h03) spc_a_r <= wdata;
      if (addr == 5'h01) dir_a_r <= wdata;
    end
  end

  rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside read answer");
  unmapped_rd_a: assert property (rd && addr[4:3] == 2'h3 |=>
    rdata == 8'h00) else $error("unmapped read not zero");
  dir_readback_a: assert property (rd && addr == 5'h01 |=>
    rdata == dir_a_r) else $error("direction readback wrong");
  dir_input_a: assert property (wr && addr == 5'h01 && wdata == 8'hff
    && !hs_a ##1 !wr [*2] |=> pa_oe_n == 8'hff)
    else $error("input bits still driven");
  mask_hold_a: assert property (wr && addr == 5'h10
    && wdata[7:4] == 4'hf ##1 !wr [*2] |=> pc_oe_n != 4'h0
    || $stable(pc_out)) else $error("protected port C bit changed");
  ack_first_a: assert property (il_out && $fell(pc_out[3]) |->
    $past(pc_in[2], 4)) else $error("data available before ready");
  data_steady_a: assert property (il_out && !pc_out[3]
    && $past(pc_out[3]) == 1'b0 |-> $stable(pa_out))
    else $error("output data moved while announced");
  hs_ctrl_out_a: assert property (hs_a [*4] |-> !pc_oe_n[3])
    else $error("handshake line not forced to output");
  hs_dir_out_a: assert property (out_a [*4] |-> pa_oe_n == 8'h00)
    else $error("output handshake port not driving");
  pend_hs_only_a: assert property ($rose(int_pending_a) |-> hs_a)
    else $error("pending raised outside handshake");

  cover property (il_out && $fell(pc_out[3]));
  cover property ($rose(int_pending_a));
  cover property (rd && addr[4:3] == 2'h3);
endmodule // gpio_hs_checker

bind gpio_hs_top gpio_hs_checker chk (.clk(clk), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pb_in(pb_in),
  .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pc_in(pc_in), .pc_out(pc_out),
  .pc_oe_n(pc_oe_n), .int_pending_a(int_pending_a),
  .int_pending_b(int_pending_b));

/* File: verification/hs_peer.sv */
// Far-side device on port A pins and port C handshake lines.
// Assumes port A handshake on line 3 (out) and line 2 (ack in).
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
module hs_peer (
  input  wire       clk,
  input  wire [1:0] pmode,
  input  wire [7:0] bit_val,
  input  wire [7:0] pa_out,
  input  wire [7:0] pa_oe_n,
  input  wire [3:0] pc_out,
  input  wire [3:0] pc_oe_n,
  output wire [7:0] pa_in,
  output wire [3:0] pc_in
);
  // pmode: 0 idle, 1 interlocked sink, 2 strobed sink, 3 source
  logic [7:0] rxq[$];
  logic [7:0] txq[$];
  logic [7:0] sdata;
  logic       ack;
  int         n;
  wire  [7:0] drv = (pmode == 2'h3) ? sdata : bit_val;

  // Undriven control lines are pulled up
  assign pa_in = (pa_out & ~pa_oe_n) | (drv & pa_oe_n);
  assign pc_in = (pc_out & ~pc_oe_n) | ({1'b1, ack, 2'h3} & pc_oe_n);

  initial begin
    ack   = 1'b1;
    sdata = 8'h00;
    forever begin
      @(posedge clk);
      if (pmode == 2'h3 && txq.size() > 0 && pc_in[3]) begin
        sdata <= txq.pop_front();
        repeat (2) @(posedge clk);
        ack <= 1'b0;
        for (n = 0; n < 60 && pc_in[3]; n++) @(posedge clk);
        ack <= 1'b1;
        sdata <= ~sdata;
        repeat (2) @(posedge clk);
      end else if (pmode != 2'h0 && pmode != 2'h3 && !pc_in[3]) begin
        // Slow taker: data is sampled only some cycles after announcing
        repeat (4) @(posedge clk);
        rxq.push_back(pa_in);
        ack <= 1'b0;
        if (pmode == 2'h2) repeat (6) @(posedge clk);
        else for (n = 0; n < 60 && !pc_in[3]; n++) @(posedge clk);
        ack <= 1'b1;
        repeat (6) @(posedge clk);
      end
    end
  end
endmodule // hs_peer

/* File: verification/parallel_ports_with_handshake_bench.sv */
// Self-checking bench: bit port, port C masking, handshake transfers.
// Assumes the checker is bound and hs_peer stands on the pins.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end

////////////////////////////////////////////////////////////////////////////
module parallel_ports_with_handshake_bench;
  logic       clk;
  logic       rst_n;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [1:0] pmode;
  logic [7:0] bit_val;
  wire  [7:0] rdata, pa_in, pa_out, pa_oe_n, pb_out, pb_oe_n;
  wire  [3:0] pc_in, pc_out, pc_oe_n;
  wire        int_pending_a, int_pending_b;
  int         n_mismatch = 0;
  int         cmp_count = 0;

  gpio_hs_top dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pa_in(pa_in), .pa_out(pa_out),
    .pa_oe_n(pa_oe_n), .pb_in(pb_out), .pb_out(pb_out),
    .pb_oe_n(pb_oe_n), .pc_in(pc_in), .pc_out(pc_out), .pc_oe_n(pc_oe_n),
    .int_pending_a(int_pending_a), .int_pending_b(int_pending_b));
  hs_peer peer (.clk(clk), .pmode(pmode), .bit_val(bit_val),
    .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pc_out(pc_out),
    .pc_oe_n(pc_oe_n), .pa_in(pa_in), .pc_in(pc_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wr_reg(input [4:0] a, input [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input [4:0] a, input [7:0] m, input [7:0] e,
                        input string nm);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(nm, e, rdata & m)
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // Bounded so a stuck handshake ends in a mismatch, not a hang
  task automatic wait_rx(input int c);
    for (int i = 0; i < 400 && peer.rxq.size() < c; i++) @(posedge clk);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    addr = 5'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    pmode = 2'h0;
    bit_val = 8'ha0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    settle(4);
    rd_chk(5'h01, 8'hff, 8'hff, "dir_a reset");
    rd_chk(5'h11, 8'h0f, 8'h0f, "dir_c reset");
    rd_chk(5'h02, 8'hff, 8'h00, "pol_a reset");
    wr_reg(5'h1a, 8'h55);
    rd_chk(5'h1a, 8'hff, 8'h00, "unmapped");
    $display("test registers done");
    wr_reg(5'h01, 8'hf0);
    wr_reg(5'h02, 8'h81);
    wr_reg(5'h03, 8'h02);
    wr_reg(5'h00, 8'h05);
    settle(4);
    `CHK("pa_out low", 4'h4, pa_out[3:0])
    `CHK("pa_oe_n", 8'hf0, pa_oe_n)
    rd_chk(5'h00, 8'hf0, 8'h20, "input read");
    wr_reg(5'h00, 8'h07);
    settle(4);
    `CHK("open drain", 8'hf2, pa_oe_n)
    wr_reg(5'h03, 8'h12);
    @(posedge clk) bit_val <= 8'hb0;
    settle(3);
    @(posedge clk) bit_val <= 8'ha0;
    settle(5);
    wr_reg(5'h00, 8'h17);
    rd_chk(5'h00, 8'h10, 8'h10, "catcher held");
    wr_reg(5'h00, 8'h07);
    rd_chk(5'h00, 8'h10, 8'h00, "catcher clear");
    wr_reg(5'h01, 8'hff);
    settle(4);
    `CHK("all inputs", 8'hff, pa_oe_n)
    $display("test bit port done");
    wr_reg(5'h11, 8'h00);
    wr_reg(5'h10, 8'h0f);
    wr_reg(5'h10, 8'h50);
    wr_reg(5'h10, 8'hf0);
    settle(4);
    `CHK("pc_out masked", 4'h5, pc_out)
    rd_chk(5'h10, 8'h0f, 8'h05, "pc pin read");
    wr_reg(5'h11, 8'h0f);
    wr_reg(5'h02, 8'h00);
    wr_reg(5'h03, 8'h00);
    $display("test port c done");
    pmode <= 2'h1;
    wr_reg(5'h04, 8'h02);
    wr_reg(5'h00, 8'h3c);
    wr_reg(5'h00, 8'hc3);
    wait_rx(2);
    settle(10);
    `CHK("rx first", 8'h3c, peer.rxq[0])
    `CHK("rx second", 8'hc3, peer.rxq[1])
    `CHK("pend out", 1'b1, int_pending_a)
    rd_chk(5'h05, 8'h01, 8'h01, "csr pend");
    wr_reg(5'h00, 8'h99);
    settle(2);
    `CHK("pend cleared", 1'b0, int_pending_a)
    wait_rx(3);
    wr_reg(5'h04, 8'h12);
    wr_reg(5'h00, 8'h11);
    wr_reg(5'h00, 8'h22);
    wait_rx(4);
    settle(8);
    `CHK("pend one byte", 1'b0, int_pending_a)
    wait_rx(5);
    settle(12);
    `CHK("pend two bytes", 1'b1, int_pending_a)
    wr_reg(5'h04, 8'h22);
    wr_reg(5'h00, 8'h44);
    wr_reg(5'h00, 8'h55);
    settle(300);
    `CHK("single count", 6, peer.rxq.size())
    `CHK("single byte", 8'h44, peer.rxq[5])
    pmode <= 2'h2;
    wr_reg(5'h04, 8'h06);
    wr_reg(5'h00, 8'h66);
    wr_reg(5'h00, 8'h77);
    wait_rx(8);
    `CHK("strobe first", 8'h66, peer.rxq[6])
    `CHK("strobe second", 8'h77, peer.rxq[7])
    settle(20);
    $display("test output handshake done");
    pmode <= 2'h1;
    wr_reg(5'h06, 8'h1f);
    wr_reg(5'h04, 8'h02);
    wr_reg(5'h00, 8'h88);
    settle(10);
    `CHK("deskew hold", 1'b1, pc_out[3])
    settle(12);
    `CHK("deskew end", 1'b0, pc_out[3])
    wait_rx(9);
    `CHK("deskew byte", 8'h88, peer.rxq[8])
    settle(8);
    wr_reg(5'h06, 8'h00);
    wr_reg(5'h04, 8'h42);
    wr_reg(5'h08, 8'hbe);
    wr_reg(5'h00, 8'hef);
    settle(3);
    `CHK("link high", 8'hbe, pb_out)
    `CHK("link oe", 8'h00, pb_oe_n)
    wait_rx(10);
    `CHK("link low", 8'hef, peer.rxq[9])
    settle(10);
    $display("test deskew and link done");
    pmode <= 2'h0;
    wr_reg(5'h04, 8'h01);
    peer.txq.push_back(8'h5a);
    peer.txq.push_back(8'ha5);
    pmode <= 2'h3;
    settle(200);
    `CHK("pend in", 1'b1, int_pending_a)
    rd_chk(5'h00, 8'hff, 8'h5a, "in first");
    rd_chk(5'h00, 8'hff, 8'ha5, "in second");
    settle(3);
    `CHK("pend read clear", 1'b0, int_pending_a)
    `CHK("pend b idle", 1'b0, int_pending_b)
    $display("test input handshake done");
    stop_test();
  end
endmodule // parallel_ports_with_handshake_bench
